// ==== core/pcg_params.svh ====
// offsets, reset values and timing counts of the clock mode generator
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH
`define PCG_ADDR_CLK_MODE   8'h58
`define PCG_ADDR_STATUS     8'h59
`define PCG_RST_X15         16'hE007
`define PCG_RST_X10         16'h9007
`define PCG_RST_X5          16'h4007
`define PCG_RST_X2          16'h1007
`define PCG_RST_X1          16'hF007
`define PCG_RST_DIV2        16'h0000
`define PCG_RST_DIV4        16'hF000
`define PCG_MULT_MSB        15
`define PCG_MULT_LSB        12
`define PCG_DIV_LSB         1
`define PCG_PLL_EN_BIT      0
`define PCG_LOCK_MSB        10
`define PCG_LOCK_LSB        3
`define PCG_LOCK_UNIT       10'd16
`endif

// ==== core/pcg_pkg.sv ====
// types of the clock mode generator
package pcg_pkg;
    typedef enum logic [1:0] {
        PCG_DIV  = 2'b00,
        PCG_LOCK = 2'b01,
        PCG_PLL  = 2'b11
    } pcg_state_t;
endpackage

// ==== core/pcg_clock_mode.sv ====
// clock mode control register, lock timer and clock mode sequencer
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "pcg_params.svh"
module pcg_clock_mode
    import pcg_pkg::*;
#(
    parameter int LOCK_W = 18
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // mode select straps
    input  wire logic        mode_select_pin_a,
    input  wire logic        mode_select_pin_b,
    input  wire logic        mode_select_pin_c,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // clock control to the analog pll and clock mux
    output logic             pll_power_on,
    output logic      [4:0]  pll_ratio,
    output logic             use_pll_clock,
    output logic      [1:0]  div_ratio_sel
);
    logic              rst_s1_ff, rst_s2_ff;
    logic [2:0]        pin_s1_ff, pin_s2_ff;
    logic              strap_done_ff;
    logic [15:0]       clk_mode_ff;
    logic [15:0]       nxt_clk_mode;
    logic [15:0]       rdata_ff;
    logic [LOCK_W-1:0] lock_cnt_ff;
    logic [LOCK_W-1:0] lock_load;
    pcg_state_t        state_ff;
    pcg_state_t        nxt_state;
    logic              pll_en;
    logic              mode_wr;
    logic              nxt_pll_en;

    // reset release through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // straps are pins, synchronised before use
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_ff <= 3'h0;
            pin_s2_ff <= 3'h0;
        end else begin
            pin_s1_ff <= {mode_select_pin_a, mode_select_pin_b,
                          mode_select_pin_c};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // reserved 011 strap falls back to divide by 2, safest clock
    function automatic logic [15:0] strap_value(input logic [2:0] p);
        unique case (p)
            3'b000:  strap_value = `PCG_RST_X15;
            3'b001:  strap_value = `PCG_RST_X10;
            3'b010:  strap_value = `PCG_RST_X5;
            3'b100:  strap_value = `PCG_RST_X2;
            3'b110:  strap_value = `PCG_RST_X1;
            3'b101:  strap_value = `PCG_RST_DIV4;
            default: strap_value = `PCG_RST_DIV2;
        endcase
    endfunction

    always_comb begin
        nxt_clk_mode = clk_mode_ff;
        if (!strap_done_ff)
            nxt_clk_mode = strap_value(pin_s2_ff);
        else if (wr && addr == `PCG_ADDR_CLK_MODE)
            nxt_clk_mode = wdata;
    end

    // strap caught on the first clock after rst_s2_ff rises, the third after rstn release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            strap_done_ff <= 1'b0;
        else if (rst_s2_ff)
            strap_done_ff <= 1'b1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            clk_mode_ff <= 16'h0000;
        else if (rst_s2_ff)
            clk_mode_ff <= nxt_clk_mode;
    end

    assign pll_en     = clk_mode_ff[`PCG_PLL_EN_BIT];
    assign mode_wr    = strap_done_ff && wr && addr == `PCG_ADDR_CLK_MODE;
    // sequencer follows the word being written, not the stale one
    assign nxt_pll_en = nxt_clk_mode[`PCG_PLL_EN_BIT];
    assign lock_load  = LOCK_W'(nxt_clk_mode[`PCG_LOCK_MSB:`PCG_LOCK_LSB])
                        * LOCK_W'(`PCG_LOCK_UNIT);

    // sequencer: divider until the lock timer expires
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PCG_DIV:  if (nxt_pll_en) nxt_state = PCG_LOCK;
            PCG_LOCK: begin
                if (!nxt_pll_en)
                    nxt_state = PCG_DIV;
                else if (lock_cnt_ff == '0)
                    nxt_state = PCG_PLL;
            end
            PCG_PLL:  if (!nxt_pll_en) nxt_state = PCG_DIV;
            default:  nxt_state = PCG_DIV;
        endcase
        // a rewrite of the mode word with the pll enable bit set restarts acquisition
        if (mode_wr && nxt_pll_en)
            nxt_state = PCG_LOCK;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            state_ff <= PCG_DIV;
        else if (!rst_s2_ff || !strap_done_ff)
            state_ff <= PCG_DIV;
        else
            state_ff <= nxt_state;
    end

    // lock timer loads on entry to acquisition
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            lock_cnt_ff <= '0;
        else if (nxt_state == PCG_LOCK && (state_ff != PCG_LOCK || mode_wr))
            lock_cnt_ff <= lock_load;
        else if (state_ff == PCG_LOCK && lock_cnt_ff != '0)
            lock_cnt_ff <= lock_cnt_ff - 1'b1;
    end

    // clock outputs
    assign pll_power_on  = pll_en && state_ff != PCG_DIV
                           || state_ff == PCG_PLL;
    assign use_pll_clock = (state_ff == PCG_PLL);
    assign pll_ratio     = {1'b0, clk_mode_ff[`PCG_MULT_MSB:`PCG_MULT_LSB]}
                           + 5'h01;
    assign div_ratio_sel = clk_mode_ff[`PCG_MULT_MSB:`PCG_MULT_LSB] == 4'hF
                           ? 2'h2 : 2'h1;

    // read port, data one cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            rdata_ff <= 16'h0000;
        else if (rd) begin
            if (addr == `PCG_ADDR_CLK_MODE)
                rdata_ff <= clk_mode_ff;
            else if (addr == `PCG_ADDR_STATUS)
                rdata_ff <= {14'h0000, state_ff};
            else
                rdata_ff <= 16'h0000;
        end else
            rdata_ff <= 16'h0000;
    end
    assign rdata = rdata_ff;
endmodule

// ==== verification/pcg_strap_board.sv ====
// board strapping of the mode select pins
`timescale 1ns/1ps
module pcg_strap_board (
    input  wire logic [2:0] pattern,
    output logic            pin_a,
    output logic            pin_b,
    output logic            pin_c
);
    // reserved 011 is never strapped; board falls back to 111
    assign {pin_a, pin_b, pin_c} = (pattern == 3'b011) ? 3'b111 : pattern;
endmodule

// ==== verification/pcg_clock_mode_checker.sv ====
// port assertions of the clock mode generator
`timescale 1ns/1ps
module pcg_clock_mode_checker #(parameter int LOCK_W = 18) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        pll_power_on,
    input wire logic [4:0]  pll_ratio,
    input wire logic        use_pll_clock
);
    wire       w = wr && addr == 8'h58;
    wire       r = rd && addr == 8'h58;
    wire [4:0] q = {1'b0, wdata[15:12]} + 5'h01;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_RDBK: assert property (w ##1 r |=> rdata == $past(wdata, 2))
        else $error("readback differs");
    AST_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("rdata not zero");
    AST_IGN: assert property (wr && !w |=> $stable(pll_ratio))
        else $error("stray write took");
    AST_RATIO: assert property (w |=> pll_ratio == $past(q))
        else $error("ratio wrong");
    AST_OFF: assert property (w && !wdata[0] |=> !pll_power_on)
        else $error("pll still on");
    // lock field counts 16-cycle units, so 8 cycles is a safe floor for any nonzero lock field
    AST_LOCK: assert property (w && wdata[0] |=> !use_pll_clock [*8])
        else $error("switched before lock");
    AST_ACQ: assert property (w && wdata[0] && wdata[10:3] == 8'h01
        |-> ##[16:24] use_pll_clock) else $error("no switch to pll");
    AST_PON: assert property (use_pll_clock |-> pll_power_on)
        else $error("pll clock while off");
    cover property (r);
    cover property ($rose(use_pll_clock));
    cover property (wr && !w);
endmodule
bind pcg_clock_mode pcg_clock_mode_checker #(.LOCK_W(LOCK_W)) u_chk (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pll_power_on(pll_power_on), .pll_ratio(pll_ratio),
    .use_pll_clock(use_pll_clock));

// ==== verification/tb_top.sv ====
// self-checking bench of the clock mode generator
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR %0t got %h want %h", $time, a, e); end end
module tb_top;
    logic        clk = 0, rstn = 0, wr = 0, rd = 0, pa, pb, pc, pon, upll;
    logic [2:0]  pat = 3'b000;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000, d, w, rdata;
    logic [4:0]  ratio_o;
    logic [1:0]  dsel;
    int          n_fail = 0, checked = 0, n, lk;
    logic [15:0] exp_rst [8] = '{16'hE007, 16'h9007, 16'h4007, 16'h0000,
                                 16'h1007, 16'hF000, 16'hF007, 16'h0000};
    always #5 clk = ~clk;
    pcg_strap_board u_pcg_strap_board (.pattern(pat), .pin_a(pa),
        .pin_b(pb), .pin_c(pc));
    pcg_clock_mode u_pcg_clock_mode (.clk(clk), .rstn(rstn),
        .mode_select_pin_a(pa), .mode_select_pin_b(pb),
        .mode_select_pin_c(pc), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pll_power_on(pon), .pll_ratio(ratio_o),
        .use_pll_clock(upll), .div_ratio_sel(dsel));
    function automatic logic [4:0] ratio(logic [15:0] m);
        return {1'b0, m[15:12]} + 5'h01;
    endfunction
    task automatic op(logic w_, logic r_, logic [7:0] a, logic [15:0] v);
        wr <= w_;
        rd <= r_;
        addr <= a;
        wdata <= v;
        @(posedge clk);
    endtask
    // rdata stands one cycle only, so sample just after its edge
    task automatic rdw(logic [7:0] a);
        op(0, 1, a, 16'h0000);
        rd <= 0;
        #1 d = rdata;
    endtask
    task automatic final_report;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h7b15));
        for (int p = 0; p < 8; p++) begin
            rstn <= 0;
            pat <= p[2:0];
            repeat (12) @(posedge clk);
            rstn <= 1;
            repeat (8) @(posedge clk);
            rdw(8'h58);
            `CHK(d, exp_rst[p])
        end
        for (int i = 0; i < 6; i++) begin
            w = $urandom;
            lk = (i == 0) ? 1 : 1 + $urandom % 3;
            w[10:3] = 8'(lk);
            w[0] = 1'b1;
            op(1, 0, 8'h58, w);
            rdw(8'h58);
            `CHK(d, w)
            `CHK(ratio_o, ratio(w))
            `CHK(upll, 1'b0)
            `CHK(pon, 1'b1)
            n = 0;
            // look after the edge has settled, not in its own time step
            while (upll !== 1'b1 && n < 2000) begin
                @(posedge clk);
                #1;
                n++;
            end
            if (n >= 2000) begin
                n_fail++;
                final_report();
            end
            `CHK(n >= lk * 16 - 4 && n <= lk * 16 + 4, 1'b1)
            rdw(8'h59);
            `CHK(d[1:0], 2'b11)
            `CHK(pon, 1'b1)
            w[0] = 1'b0;
            op(1, 0, 8'h58, w);
            op(1, 0, 8'h5A, ~w);
            rdw(8'h58);
            `CHK(d, w)
            `CHK({upll, pon}, 2'b00)
            `CHK(dsel, (w[15:12] == 4'hF) ? 2'd2 : 2'd1)
            rdw(8'h5A);
            `CHK(d, 16'h0000)
        end
        final_report();
    end
endmodule
